// ---- src/sacs_pkg.sv ----
package sacs_pkg;

  // ------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------
  localparam int unsigned RES_BITS      = 12;
  localparam int unsigned SHORT_BITS    = 8;
  localparam int unsigned ACQ_CYCLES    = 2;
  localparam int unsigned CLK_DIV       = 4;
  localparam logic [3:0]  MSB_IDX       = 4'hB;
  localparam logic [3:0]  SHORT_END_IDX = 4'h4;
  localparam logic [11:0] RESULT_RESET  = 12'h000;
  localparam logic [4:0]  PIN_IDLE      = 5'h0F;  // Pins inactive in reset

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SACS_IDLE    = 4'b0001,
    SACS_ACQUIRE = 4'b0010,
    SACS_HOLD    = 4'b0100,
    SACS_TEST    = 4'b1000
  } sacs_state_t;

  // Host control pins
  typedef struct packed {
    logic chip_enable;
    logic chip_select_n;
    logic read_not_convert;
    logic cycle_length_select;
    logic full_width_read;
  } sacs_ctrl_t;

  // Analog front-end controls
  typedef struct packed {
    logic       track;
    logic [11:0] trial_code;
  } sacs_afe_t;

endpackage

// ---- src/sacs_sequencer.sv ----
`timescale 1ns/1ns
// Function
// R1: Accepted start enables the clock and clears the approximation register.
// R2: Busy conversion ignores restart attempts; result hidden until finished.
// R3: At end of conversion clock stops, status drops, reads allowed.
// R4: Trial twelve bits MSB first; keep a bit when its sum is below input.
// R5: Sampling and conversion timing starts on read/convert falling edge; code starts when the last of chip enable, select and read/convert arrives.
// R6: Exactly two internal clock cycles acquire, then sample is held.
// R7: Once the sample is captured the input stays isolated until the end.
// R8: Acquisition counted in internal clock cycles.
// R9: Bit testing lasts a fixed number of internal clock cycles.
// R10: Status high only during conversion; data lines off, starts ignored.
// R11: Start latches cycle length select; high gives 8 bits, low 12.
// R12: Result stays latched unchanged until the next conversion starts.
module sacs_sequencer
  import sacs_pkg::*;
#(
  parameter int unsigned CLK_DIV_P = CLK_DIV
)(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire sacs_pkg::sacs_ctrl_t ctrl,
  input  wire logic                 comp_below,
  output logic                      conversion_status_out,
  output sacs_pkg::sacs_afe_t       afe,
  output logic                      conv_clk_en,
  output logic [11:0]               data_out,
  output logic [11:0]               data_oe
);
  import sacs_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers, one chain per control pin
  // ------------------------------------------------------------
  logic [4:0] ctrl_bits;
  logic [4:0] pins;

  // Struct flattened so every pin gets a chain of its own
  assign ctrl_bits = ctrl;

  for (genvar gi = 0; gi < $bits(sacs_ctrl_t); gi++)
  begin : g_pin_sync
    logic s1;
    logic s2;
    logic s3;
    logic lvl;

    // Level taken once stages two and three agree
    always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
        s1  <= PIN_IDLE[gi];
        s2  <= PIN_IDLE[gi];
        s3  <= PIN_IDLE[gi];
        lvl <= PIN_IDLE[gi];
      end
      else
      begin
        s1  <= ctrl_bits[gi];
        s2  <= s1;
        s3  <= s2;
        lvl <= (s2 == s3) ? s3 : lvl;
      end

    // Qualified level of this pin
    assign pins[gi] = lvl;
  end

  // Qualified pin levels, bit order as in the struct
  wire ce_s  = pins[4];
  wire csn_s = pins[3];
  wire rc_s  = pins[2];
  wire cls_s = pins[1];
  wire fw_s  = pins[0];

  // ------------------------------------------------------------
  // Start detection
  // ------------------------------------------------------------
  // Start condition: last of three inputs reaching convert state
  wire start_lvl = ce_s & ~csn_s & ~rc_s;
  logic start_prev;
  wire start_edge = start_lvl & ~start_prev;  // R5

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Sequencer state and counters
  sacs_state_t state;
  logic [7:0]  div_cnt;
  logic [1:0]  acq_cnt;
  logic [3:0]  bit_idx;
  logic [11:0] sar;
  logic [11:0] result;
  logic        short_cycle;

  // Phase decode and internal clock tick
  wire idle      = (state == SACS_IDLE);
  wire accept    = idle & start_edge;  // R2 R10
  wire tick      = (div_cnt == 8'(CLK_DIV_P - 1));

  // ------------------------------------------------------------
  // Bit trial datapath
  // ------------------------------------------------------------
  // First trial, then mask, kept value and next trial per bit
  wire [11:0] first_trial = 12'h001 << MSB_IDX;
  wire last_bit  = short_cycle ? (bit_idx == SHORT_END_IDX)
                               : (bit_idx == 4'h0);  // R11
  wire [11:0] bit_mask = 12'h001 << bit_idx;
  wire [11:0] kept     = comp_below ? sar : (sar & ~bit_mask);  // R4
  wire [11:0] next_sar = last_bit ? kept : (kept | (bit_mask >> 1));
  wire        eoc      = (state == SACS_TEST) & tick & last_bit;

  // Start edge tracking
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      start_prev <= 1'b0;
    else
      start_prev <= start_lvl;

  // Internal conversion clock divider, runs only while busy
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      div_cnt <= 8'h00;
    else if (idle || tick)
      div_cnt <= 8'h00;
    else
      div_cnt <= div_cnt + 8'h01;  // R8 R9

  // State machine
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      state       <= SACS_IDLE;
      acq_cnt     <= 2'h0;
      bit_idx     <= MSB_IDX;
      sar         <= RESULT_RESET;
      short_cycle <= 1'b0;
    end
    else
    begin
      case (state)
        SACS_IDLE:
          if (accept)
          begin
            state       <= SACS_ACQUIRE;
            sar         <= RESULT_RESET;  // R1
            acq_cnt     <= 2'h0;
            short_cycle <= cls_s;  // R11
          end
        SACS_ACQUIRE:
          if (tick)
          begin
            acq_cnt <= acq_cnt + 2'h1;
            if (acq_cnt == 2'(ACQ_CYCLES - 1))
              state <= SACS_HOLD;  // R6
          end
        SACS_HOLD:
          if (tick)
          begin
            state   <= SACS_TEST;
            bit_idx <= MSB_IDX;
            sar     <= first_trial;  // First trial is the MSB
          end
        SACS_TEST:
          if (tick)
          begin
            sar     <= next_sar;
            bit_idx <= bit_idx - 4'h1;
            if (last_bit)
              state <= SACS_IDLE;  // R3
          end
        default:
          state <= SACS_IDLE;
      endcase
    end

  // ------------------------------------------------------------
  // Result latch
  // ------------------------------------------------------------
  // Result latch, loaded only at end of conversion
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      result <= RESULT_RESET;
    else if (eoc)
      result <= next_sar;  // R12

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Status and conversion clock enable
  assign conversion_status_out = ~idle;  // R10 R3
  assign conv_clk_en           = ~idle;  // R1 R3

  // Analog front end: track, then held trial code
  assign afe.track             = (state == SACS_ACQUIRE);  // R6 R7
  assign afe.trial_code        = sar;

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Enable patterns of the three read formats
  wire [11:0] oe_full  = 12'hFFF;
  wire [11:0] oe_upper = 12'hFF0;
  wire [11:0] oe_nib   = 12'hF00;

  // Read decode: full, 8 MSBs, or 4 LSBs with trailing zeros
  wire read_en   = idle & ce_s & ~csn_s & rc_s;  // R2 R3 R10
  wire [11:0] low_nib = {result[3:0], 8'h00};
  wire [11:0] sel = (fw_s || !cls_s) ? result : low_nib;
  wire [11:0] oe  = fw_s ? oe_full
                  : (cls_s ? oe_nib : oe_upper);

  // Read data register, zero while the port is off
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      data_out <= 12'h000;
    else
      data_out <= read_en ? sel : 12'h000;  // R12

  // Per-bit output enables, all off while busy
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      data_oe <= 12'h000;
    else
      data_oe <= read_en ? oe : 12'h000;  // R2 R10

endmodule // sacs_sequencer

// ---- sim/sacs_seq_properties.sv ----
`timescale 1ns/1ns
module sacs_seq_properties
  import sacs_pkg::*;
#(
  parameter int unsigned CLK_DIV_P = CLK_DIV
)(
  input wire logic        clk,
  input wire logic        nrst,
  input wire sacs_ctrl_t  ctrl,
  input wire logic        comp_below,
  input wire logic        conversion_status_out,
  input wire sacs_afe_t   afe,
  input wire logic        conv_clk_en,
  input wire logic [11:0] data_out,
  input wire logic [11:0] data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] busy;
  // Length of the current busy run
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) busy <= 8'h00;
    else busy <= conversion_status_out ? busy + 8'h01 : 8'h00;
  chk_busy_no_oe: assert property (
    conversion_status_out |-> data_oe == 12'h000) else $error("oe busy");
  chk_track_busy: assert property (
    afe.track |-> conversion_status_out) else $error("track idle");
  chk_clk_on: assert property (
    $rose(conversion_status_out) |-> conv_clk_en) else $error("clk off");
  chk_sar_clear: assert property (
    $rose(conversion_status_out) |-> afe.trial_code == 12'h000)
    else $error("sar not clear");
  chk_clk_off: assert property (
    $fell(conversion_status_out) |-> !conv_clk_en) else $error("clk on");
  chk_acq_len: assert property (
    $rose(conversion_status_out) |-> afe.track [*8] ##1 !afe.track)
    else $error("acquire length");
  chk_input_isolated: assert property (
    conversion_status_out && !afe.track |=> !afe.track
      || !conversion_status_out) else $error("input reconnected");
  chk_busy_len: assert property (
    $fell(conversion_status_out) |-> busy == (RES_BITS + 3) * CLK_DIV_P
      || busy == (SHORT_BITS + 3) * CLK_DIV_P) else $error("busy length");
endmodule // sacs_seq_properties

// ---- sim/sacs_afe_model.sv ----
`timescale 1ns/1ns
module sacs_afe_model
  import sacs_pkg::*;
(
  input  wire sacs_afe_t   afe,
  input  wire logic [11:0] vin,
  output logic             comp_below
);
  logic [11:0] held;
  // Sample kept on the capacitors once tracking ends
  always @(negedge afe.track) held = vin;
  // Input sits half a step above the code, so equal counts as below
  assign comp_below = afe.trial_code <= held;
endmodule // sacs_afe_model

// ---- sim/sar_conversion_sequencer_test.sv ----
`timescale 1ns/1ns
module sar_conversion_sequencer_test;
  import sacs_pkg::*;
  logic        clk, nrst, comp_below, conversion_status_out, conv_clk_en;
  sacs_ctrl_t  ctrl;
  sacs_afe_t   afe;
  logic [11:0] data_out, data_oe, vin;
  int          error_cnt = 0, checked = 0, cyc = 0, h;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
  sacs_sequencer DUT (.clk(clk), .nrst(nrst), .ctrl(ctrl),
    .comp_below(comp_below), .conversion_status_out(conversion_status_out),
    .afe(afe), .conv_clk_en(conv_clk_en), .data_out(data_out),
    .data_oe(data_oe));
  sacs_afe_model afe_m (.afe(afe), .vin(vin), .comp_below(comp_below));
  // Clock and hang guard
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Ceiling far above the few hundred cycles the scenarios need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      stop_test;
    end
  end
  task step(input int k); repeat (k) @(posedge clk); #1; endtask
  // Start, then count busy cycles; g pokes a restart and moves the input
  task conv(input logic s, g);
    ctrl.cycle_length_select = s;
    ctrl.read_not_convert = 0;
    h = 0;
    while (!conversion_status_out && h < 40) begin step(1); h++; end
    ctrl.read_not_convert = 1;
    h = 0;
    while (conversion_status_out && h < 200)
    begin
      ctrl.read_not_convert = !(g && h inside {[20:29]});
      if (g && h == 30) vin = 12'h000;
      step(1);
      h++;
    end
  endtask
  task rd(input logic f, s, input logic [11:0] d, o);
    ctrl.full_width_read = f;
    ctrl.cycle_length_select = s;
    step(8);
    `CHK(data_out & o, d)
    `CHK(data_oe, o)
  endtask
  task t_full;
    vin = 12'hA5C;
    conv(0, 0);
    `CHK(h, 60)
    rd(1, 0, 12'hA5C, 12'hFFF);
    rd(0, 0, 12'hA50, 12'hFF0);
    rd(0, 1, 12'hC00, 12'hF00);
    rd(1, 0, 12'hA5C, 12'hFFF);
  endtask
  task t_short;
    vin = 12'h3E7;
    conv(1, 0);
    `CHK(h, 44)
    rd(1, 0, 12'h3E0, 12'hFFF);
  endtask
  task t_busy;
    vin = 12'h801;
    conv(0, 1);
    `CHK(h, 60)
    rd(1, 1, 12'h801, 12'hFFF);
  endtask
  task stop_test;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 0;
    vin = 12'h000;
    ctrl = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    step(6);
    nrst = 1;
    step(6);
    t_full;
    t_short;
    t_busy;
    stop_test;
  end
endmodule // sar_conversion_sequencer_test
bind sacs_sequencer sacs_seq_properties #(.CLK_DIV_P(CLK_DIV_P)) u_props (
  .clk(clk), .nrst(nrst), .ctrl(ctrl), .comp_below(comp_below),
  .conversion_status_out(conversion_status_out), .afe(afe),
  .conv_clk_en(conv_clk_en), .data_out(data_out), .data_oe(data_oe));
